// ---- logic/fpq_pkg.sv ----
package fpq_pkg;
    // Bus widths of the flash side
    localparam int ADDR_W = 21;
    localparam int DATA_W = 8;
    // Command and address constants of the flash
    localparam logic [7:0]  CMD_QUERY   = 8'h98;
    localparam logic [20:0] ADDR_QUERY  = 21'h000055;
    localparam logic [7:0]  CMD_RESET   = 8'hf0;
    localparam logic [7:0]  CMD_UNLK1   = 8'haa;
    localparam logic [7:0]  CMD_UNLK2   = 8'h55;
    localparam logic [7:0]  CMD_IDENT   = 8'h90;
    localparam logic [20:0] ADDR_UNLK1  = 21'h000555;
    localparam logic [20:0] ADDR_UNLK2  = 21'h0002aa;
    localparam logic [20:0] ADDR_PROT   = 21'h000002;
    localparam logic [7:0]  PROT_YES    = 8'h01;
    // Strobe timing; STROBE_NS of 50 ns sets the strobe width, above the 5 ns glitch limit
    localparam int CLK_NS      = 10;
    localparam int GLITCH_NS   = 5;
    localparam int STROBE_NS   = 50;
    localparam int STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int GAP_CYC     = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W       = 4;
    // Command register offsets of this controller
    localparam logic [3:0] REG_ADDR   = 4'h0;
    localparam logic [3:0] REG_WDATA  = 4'h1;
    localparam logic [3:0] REG_CTRL   = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_RDATA  = 4'h4;
    // Control operations written to REG_CTRL
    localparam logic [2:0] OP_WRITE   = 3'h1;
    localparam logic [2:0] OP_READ    = 3'h2;
    localparam logic [2:0] OP_QUERY   = 3'h3;
    localparam logic [2:0] OP_RESET   = 3'h4;
    localparam logic [2:0] OP_PROTCHK = 3'h5;
    localparam logic [2:0] OP_IDENT   = 3'h6;
    // Reset values
    localparam logic [20:0] ADDR_RST  = 21'h000000;
    localparam logic [7:0]  BYTE_RST  = 8'h00;
    typedef enum logic [2:0] {
        S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_GAP
    } fpq_state_t;
endpackage : fpq_pkg

// ---- logic/fpq_host.sv ----
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
// Host controller driving an asynchronous byte-wide flash bus
module fpq_host (
    input  wire logic        ref_clk_in,
    input  wire logic        rstn_in,
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [31:0] reg_rdata_out,
    output logic      [20:0] flash_addr_out,
    output logic      [7:0]  data_lines_out,
    output logic             data_lines_oe_n_out,
    input  wire logic [7:0]  data_lines_in,
    output logic             flash_ce_n_out,
    output logic             flash_we_n_out,
    output logic             flash_oe_n_out,
    output logic             reset_hv_out,
    output logic             flash_reset_n_out
);
    // ==================================================================
    // Register file
    logic [20:0] addr_reg;
    logic [7:0]  wdata_reg;
    logic [7:0]  rdata_reg;
    logic        temp_unprot_reg;
    logic        busy_reg;
    logic        query_reg;
    logic        ident_reg;
    logic        prot_reg;
    logic [2:0]  op_reg;
    logic [31:0] rdata_next;
    logic [7:0]  pin_s1_reg;
    logic [7:0]  pin_s2_reg;

    wire sel_addr   = reg_addr_in == fpq_pkg::REG_ADDR;
    wire sel_wdata  = reg_addr_in == fpq_pkg::REG_WDATA;
    wire sel_ctrl   = reg_addr_in == fpq_pkg::REG_CTRL;
    wire sel_status = reg_addr_in == fpq_pkg::REG_STATUS;
    wire sel_rdata  = reg_addr_in == fpq_pkg::REG_RDATA;
    // A new operation is only taken while idle; others are dropped
    wire [2:0] ctrl_op = reg_wdata_in[2:0];
    wire start = reg_wr_in && sel_ctrl && !busy_reg && ctrl_op != 3'h0;
    wire [31:0] status_word = {26'h0, prot_reg, ident_reg, query_reg,
                               temp_unprot_reg, 1'b0, busy_reg};

    assign rdata_next = !reg_rd_in  ? 32'h0 :
                        sel_addr    ? {11'h0, addr_reg} :
                        sel_wdata   ? {24'h0, wdata_reg} :
                        sel_ctrl    ? {28'h0, temp_unprot_reg, op_reg} :
                        sel_status  ? status_word :
                        sel_rdata   ? {24'h0, rdata_reg} : 32'h0;

    // ==================================================================
    // Bus sequencer
    fpq_pkg::fpq_state_t state_reg;
    logic [3:0] cnt_reg;
    logic [1:0] step_reg;
    logic       is_read;

    // Reads keep write-strobe high; writes keep output-enable high
    assign is_read = (op_reg == fpq_pkg::OP_READ) ||
                     (op_reg == fpq_pkg::OP_PROTCHK && step_reg == 2'd0);

    // Address and data presented per step of the sequence
    logic [20:0] step_addr;
    logic [7:0]  step_data;
    always_comb begin
        step_addr = addr_reg;
        step_data = wdata_reg;
        case (op_reg)
            fpq_pkg::OP_QUERY: begin
                step_addr = fpq_pkg::ADDR_QUERY;
                step_data = fpq_pkg::CMD_QUERY;
            end
            fpq_pkg::OP_RESET: begin // Address is don't care
                step_data = fpq_pkg::CMD_RESET;
            end
            fpq_pkg::OP_PROTCHK: begin // Sector plus offset 02h
                step_addr = {addr_reg[20:16], 16'h0} | fpq_pkg::ADDR_PROT;
            end
            fpq_pkg::OP_IDENT: begin
                if (step_reg == 2'd2) begin
                    step_addr = fpq_pkg::ADDR_UNLK1;
                    step_data = fpq_pkg::CMD_UNLK1;
                end else if (step_reg == 2'd1) begin
                    step_addr = fpq_pkg::ADDR_UNLK2;
                    step_data = fpq_pkg::CMD_UNLK2;
                end else begin
                    step_addr = fpq_pkg::ADDR_UNLK1;
                    step_data = fpq_pkg::CMD_IDENT;
                end
            end
            default: begin
                step_addr = addr_reg;
                step_data = wdata_reg;
            end
        endcase
    end

    wire cnt_done = cnt_reg == 4'(fpq_pkg::STROBE_CYC - 1);
    wire gap_done = cnt_reg == 4'(fpq_pkg::GAP_CYC - 1);

    // Pin input synchroniser
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pin_s1_reg <= fpq_pkg::BYTE_RST;
            pin_s2_reg <= fpq_pkg::BYTE_RST;
        end else begin
            pin_s1_reg <= data_lines_in;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // Software registers
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            addr_reg        <= fpq_pkg::ADDR_RST;
            wdata_reg       <= fpq_pkg::BYTE_RST;
            temp_unprot_reg <= 1'b0;
            reg_rdata_out   <= 32'h0;
        end else begin
            reg_rdata_out <= rdata_next;
            if (reg_wr_in && sel_addr)
                addr_reg <= reg_wdata_in[20:0];
            if (reg_wr_in && sel_wdata)
                wdata_reg <= reg_wdata_in[7:0];
            // High voltage on reset input only; idle bus when switching
            if (reg_wr_in && sel_ctrl && !busy_reg)
                temp_unprot_reg <= reg_wdata_in[3];
        end
    end

    // Strobe sequencer; strobes last 50 ns, well above the glitch limit
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= fpq_pkg::S_IDLE;
            cnt_reg   <= 4'h0;
            step_reg  <= 2'd0;
            op_reg    <= 3'h0;
            busy_reg  <= 1'b0;
        end else begin
            case (state_reg)
                fpq_pkg::S_IDLE: begin
                    if (start) begin
                        op_reg    <= ctrl_op;
                        busy_reg  <= 1'b1;
                        step_reg  <= (ctrl_op == fpq_pkg::OP_IDENT) ?
                                     2'd2 : 2'd0;
                        state_reg <= fpq_pkg::S_SETUP;
                    end
                end
                fpq_pkg::S_SETUP: begin
                    cnt_reg   <= 4'h0;
                    state_reg <= fpq_pkg::S_STROBE;
                end
                fpq_pkg::S_STROBE: begin
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_done)
                        state_reg <= fpq_pkg::S_HOLD;
                end
                fpq_pkg::S_HOLD: begin
                    cnt_reg   <= 4'h0;
                    state_reg <= fpq_pkg::S_GAP;
                end
                fpq_pkg::S_GAP: begin
                    cnt_reg <= cnt_reg + 4'h1;
                    if (gap_done) begin
                        if (step_reg != 2'd0) begin
                            step_reg  <= step_reg - 2'd1;
                            state_reg <= fpq_pkg::S_SETUP;
                        end else begin
                            busy_reg  <= 1'b0;
                            state_reg <= fpq_pkg::S_IDLE;
                        end
                    end
                end
                default: state_reg <= fpq_pkg::S_IDLE;
            endcase
        end
    end

    // Mode tracking and captured read data
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            query_reg <= 1'b0; // Device starts in array read
            ident_reg <= 1'b0;
            prot_reg  <= 1'b0;
            rdata_reg <= fpq_pkg::BYTE_RST;
        end else if (state_reg == fpq_pkg::S_HOLD) begin
            if (is_read)
                rdata_reg <= pin_s2_reg;
            if (op_reg == fpq_pkg::OP_PROTCHK)
                prot_reg <= pin_s2_reg == fpq_pkg::PROT_YES;
            if (op_reg == fpq_pkg::OP_QUERY)
                query_reg <= 1'b1;
            if (op_reg == fpq_pkg::OP_IDENT && step_reg == 2'd0)
                ident_reg <= 1'b1;
            // Reset leaves query first, back to ident if it came from there
            if (op_reg == fpq_pkg::OP_RESET) begin
                if (query_reg)
                    query_reg <= 1'b0;
                else
                    ident_reg <= 1'b0;
            end
        end
    end

    // ==================================================================
    // Pin drivers, all registered
    wire strobe_on = state_reg == fpq_pkg::S_STROBE;
    wire drive_on  = !is_read && state_reg != fpq_pkg::S_IDLE;
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            // Idle bus: write-strobe and chip-select high
            flash_addr_out      <= fpq_pkg::ADDR_RST;
            data_lines_out      <= fpq_pkg::BYTE_RST;
            data_lines_oe_n_out <= 1'b1;
            flash_ce_n_out      <= 1'b1;
            flash_we_n_out      <= 1'b1;
            flash_oe_n_out      <= 1'b1;
            reset_hv_out        <= 1'b0;
            flash_reset_n_out   <= 1'b0;
        end else begin
            flash_reset_n_out   <= 1'b1;
            // Only the reset pin ever gets the high voltage
            reset_hv_out        <= temp_unprot_reg;
            flash_addr_out      <= step_addr;
            data_lines_out      <= step_data;
            data_lines_oe_n_out <= !drive_on;
            flash_ce_n_out      <= !strobe_on;
            // Writes: chip-select and write-strobe low, output-enable high
            flash_we_n_out      <= !(strobe_on && !is_read);
            flash_oe_n_out      <= !(strobe_on && is_read);
        end
    end

    // Never drive both strobes low together
    a_strobe_excl: assert property (
        @(posedge ref_clk_in) disable iff (!rstn_in)
        !(!flash_we_n_out && !flash_oe_n_out))
        else $error("write and output strobes low together");
    // Write strobe pulse spans several cycles
    a_strobe_wide: assert property (
        @(posedge ref_clk_in) disable iff (!rstn_in)
        $fell(flash_we_n_out) |-> !flash_we_n_out [*5])
        else $error("write strobe too short");
    // Data driven while write strobe low
    a_write_drive: assert property (
        @(posedge ref_clk_in) disable iff (!rstn_in)
        !flash_we_n_out |-> !data_lines_oe_n_out && !flash_ce_n_out)
        else $error("write without driven data");
    // Reads keep the host off the data lines to avoid contention
    a_read_release: assert property (
        @(posedge ref_clk_in) disable iff (!rstn_in)
        !flash_oe_n_out |-> flash_we_n_out && data_lines_oe_n_out)
        else $error("read while host drives the data lines");
    // Query entry goes out as its fixed code at its fixed address
    a_query_cmd: assert property (
        @(posedge ref_clk_in) disable iff (!rstn_in)
        !flash_we_n_out && op_reg == fpq_pkg::OP_QUERY |->
        data_lines_out == fpq_pkg::CMD_QUERY &&
        flash_addr_out == fpq_pkg::ADDR_QUERY)
        else $error("query write with wrong address or data");
    // Reset command always carries its code; address is free
    a_reset_cmd: assert property (
        @(posedge ref_clk_in) disable iff (!rstn_in)
        !flash_we_n_out && op_reg == fpq_pkg::OP_RESET |->
        data_lines_out == fpq_pkg::CMD_RESET)
        else $error("reset write with wrong data");
    // Identification entry opens with the first unlock cycle
    a_ident_unlock: assert property (
        @(posedge ref_clk_in) disable iff (!rstn_in)
        $fell(flash_we_n_out) && op_reg == fpq_pkg::OP_IDENT &&
        step_reg == 2'd2 |-> data_lines_out == fpq_pkg::CMD_UNLK1 &&
        flash_addr_out == fpq_pkg::ADDR_UNLK1)
        else $error("identification entry without unlock cycle");
    // High voltage pin follows the control bit one cycle later
    a_hv_follow: assert property (
        @(posedge ref_clk_in) disable iff (!rstn_in)
        reset_hv_out == $past(temp_unprot_reg))
        else $error("reset high voltage out of step with control");
endmodule : fpq_host

// ---- sim/fpq_flash_model.sv ----
`timescale 1ns/1ns
// =====================================
// Behavioural flash device facing the host controller
module fpq_flash_model (
    input  wire logic [20:0] addr_in,
    input  wire logic [7:0]  dq_in,
    input  wire logic        ce_n_in,
    input  wire logic        we_n_in,
    input  wire logic        oe_n_in,
    input  wire logic        reset_hv_in,
    input  wire logic        reset_n_in,
    output logic      [7:0]  dq_out
);
    // Query table, offset 10h in the top byte down to 4Ch
    localparam logic [487:0] TABLE = {
        88'h5152_5902_0040_0000_0000_00,
        96'h2736_0000_0400_0a00_0500_0400,
        176'h1500_0000_0001_1f00_0001_0000_0000_0000_8000_0000_0000,
        24'h00_0000,
        104'h5052_4931_3001_0201_0104_0000_00};
    typedef enum logic [1:0] {M_ARRAY, M_IDENT, M_QUERY} fpq_mode_t;
    fpq_mode_t   mode_q     = M_ARRAY;
    logic        from_ident = 1'b0;
    logic [1:0]  step_q     = 2'h0;
    logic [31:0] prot_q     = 32'h0;
    logic        supply_ok  = 1'b1;    // Bench drops it for a brown-out
    logic [7:0]  mem [int];
    logic [7:0]  rd_val;
    logic [7:0]  last_q     = 8'h00;
    time         t0         = 0;
    // Only the low address byte picks an entry
    function automatic logic [7:0] cfi(input logic [7:0] off);
        if (off < 8'h10 || off > 8'h4c)
            return 8'h00;
        return TABLE[8*(8'h4c - off) +: 8];
    endfunction : cfi
    // A write needs both strobes low with outputs off
    wire wr_low = !we_n_in && !ce_n_in && oe_n_in && reset_n_in &&
                  supply_ok;
    wire drv    = !ce_n_in && !oe_n_in && we_n_in && reset_n_in;
    always @(posedge wr_low) t0 = $time;
    // =====================================
    // Command decode at the end of each write; short pulses are noise
    always @(negedge wr_low) begin
        // A write already open at power-up carries no command
        if ($time - t0 >= 5 && t0 != 0) begin
            if (step_q == 2'h3) begin
                if (!prot_q[addr_in[20:16]] || reset_hv_in)
                    mem[int'(addr_in)] = dq_in;
                step_q = 2'h0;
            end else if (dq_in == 8'hf0) begin
                mode_q = (mode_q == M_QUERY && from_ident) ? M_IDENT : M_ARRAY;
                step_q = 2'h0;
            end else if (dq_in == 8'h98 &&
                         addr_in[7:0] == 8'h55) begin
                from_ident = (mode_q == M_IDENT);
                mode_q = M_QUERY;
            end else if (step_q == 2'h0 && dq_in == 8'haa &&
                         addr_in[10:0] == 11'h555)
                step_q = 2'h1;
            else if (step_q == 2'h1 && dq_in == 8'h55 &&
                     addr_in[10:0] == 11'h2aa)
                step_q = 2'h2;
            else if (step_q == 2'h2 && dq_in == 8'ha0)
                step_q = 2'h3;
            else begin
                mode_q = (step_q == 2'h2 && dq_in == 8'h90) ? M_IDENT : mode_q;
                step_q = 2'h0;
            end
        end
    end
    // Hardware reset or a supply drop below lockout clears any mode
    always @(negedge reset_n_in or negedge supply_ok) begin
        mode_q = M_ARRAY;
        step_q = 2'h0;
    end
    // Read path; a released bus shows the inverse of the last byte
    always @* begin
        if (mode_q == M_QUERY)
            rd_val = cfi(addr_in[7:0]);
        else if (mode_q == M_IDENT)
            rd_val = (addr_in[7:0] == 8'h02) ?
                     {7'h0, prot_q[addr_in[20:16]]} : 8'h00;
        else
            rd_val = mem.exists(int'(addr_in)) ? mem[int'(addr_in)] : 8'hff;
    end
    always @(drv or rd_val) if (drv) last_q = rd_val;
    assign dq_out = drv ? rd_val : ~last_q;
endmodule : fpq_flash_model

// ---- sim/fpq_host_bench.sv ----
`timescale 1ns/1ns
module fpq_host_bench;
    logic        ref_clk_in   = 1'b0;
    logic        rstn_in      = 1'b0;
    logic [3:0]  reg_addr_in  = 4'h0;
    logic [31:0] reg_wdata_in = 32'h0;
    logic        reg_wr_in    = 1'b0;
    logic        reg_rd_in    = 1'b0;
    logic [31:0] reg_rdata_out, last_rd;
    logic [20:0] fa, a0;
    logic [7:0]  dq_host, dq_dev, d, e;
    logic        dq_oe_n, ce_n, we_n, oe_n, hv, frst_n;
    logic        temp = 1'b0;
    logic        rd_seen = 1'b0;
    logic [63:0] exp_q[$];
    int          failures = 0;
    int          samples_checked = 0;
    // Query table by rule, offset 10h in the top byte down to 4Ch
    localparam logic [487:0] CFI_TAB = {
        88'h5152_5902_0040_0000_0000_00,
        96'h2736_0000_0400_0a00_0500_0400,
        176'h1500_0000_0001_1f00_0001_0000_0000_0000_8000_0000_0000,
        24'h00_0000,
        104'h5052_4931_3001_0201_0104_0000_00};
    wire  [7:0]  dq_bus = !dq_oe_n ? dq_host : dq_dev;
    fpq_host DUT (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .flash_addr_out(fa),
        .data_lines_out(dq_host), .data_lines_oe_n_out(dq_oe_n),
        .data_lines_in(dq_bus), .flash_ce_n_out(ce_n),
        .flash_we_n_out(we_n), .flash_oe_n_out(oe_n),
        .reset_hv_out(hv), .flash_reset_n_out(frst_n));
    fpq_flash_model FLASH (.addr_in(fa), .dq_in(dq_bus), .ce_n_in(ce_n),
        .we_n_in(we_n), .oe_n_in(oe_n), .reset_hv_in(hv),
        .reset_n_in(frst_n), .dq_out(dq_dev));
    initial forever #5 ref_clk_in = ~ref_clk_in;
    // =====================================
    // Read data stands one cycle after the strobe; compare it there
    always @(posedge ref_clk_in) begin
        if (rd_seen && exp_q.size() > 0) begin
            last_rd = reg_rdata_out;
            if (|exp_q[0][63:32]) begin
                samples_checked++;
                if ((reg_rdata_out & exp_q[0][63:32]) !== exp_q[0][31:0]) begin
                    failures++;
                    $display("mismatch at %0t: read %h", $time, reg_rdata_out);
                end
            end
            void'(exp_q.pop_front());
        end
        rd_seen <= reg_rd_in;
    end
    // Gap cycle after each strobe keeps one assignment per time step
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        reg_addr_in  <= a;
        reg_wdata_in <= v;
        reg_wr_in    <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_in    <= 1'b0;
        @(posedge ref_clk_in);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] m, v);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        exp_q.push_back({m, v});
        @(posedge ref_clk_in);
        reg_rd_in   <= 1'b0;
        @(posedge ref_clk_in);
    endtask : rd
    task automatic st(input logic [31:0] m, v);
        rd(fpq_pkg::REG_STATUS, m, v);
    endtask : st
    task automatic close_out();
        $display("checked %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out
    // Busy is polled with a bound; a hang ends the run
    task automatic wait_idle();
        for (int i = 0; i < 40; i++) begin
            st(32'h0, 32'h0);
            #1;
            @(posedge ref_clk_in);
            if (last_rd[0] === 1'b0) return;
        end
        failures++;
        $display("mismatch at %0t: controller stays busy", $time);
        close_out();
    endtask : wait_idle
    task automatic op(input logic [20:0] a, input logic [7:0] v,
                      input logic [2:0] o);
        wr(fpq_pkg::REG_ADDR, {11'h0, a});
        wr(fpq_pkg::REG_WDATA, {24'h0, v});
        wr(fpq_pkg::REG_CTRL, {28'h0, temp, o});
        wait_idle();
    endtask : op
    task automatic rdb(input logic [20:0] a, input logic [7:0] e);
        op(a, 8'h00, fpq_pkg::OP_READ);
        rd(fpq_pkg::REG_RDATA, 32'hff, {24'h0, e});
    endtask : rdb
    task automatic prog(input logic [20:0] a, input logic [7:0] v);
        op(fpq_pkg::ADDR_UNLK1, fpq_pkg::CMD_UNLK1, fpq_pkg::OP_WRITE);
        op(fpq_pkg::ADDR_UNLK2, fpq_pkg::CMD_UNLK2, fpq_pkg::OP_WRITE);
        op(fpq_pkg::ADDR_UNLK1, 8'ha0, fpq_pkg::OP_WRITE);
        op(a, v, fpq_pkg::OP_WRITE);
    endtask : prog
    task automatic pin(input logic got, exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: pin level %b", $time, got);
        end
    endtask : pin
    // =====================================
    // Main sequence
    initial begin
        void'($urandom(26313));
        repeat (16) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        @(posedge ref_clk_in);
        a0 = 21'($urandom());
        d  = {1'b0, 7'($urandom())};
        st(32'h3d, 32'h0);
        rd(4'hf, 32'hffff_ffff, 32'h0);
        rdb(a0, 8'hff);
        // Protection is only reported while in identification mode
        op(21'h0, 8'h00, fpq_pkg::OP_IDENT);
        op(a0, 8'h00, fpq_pkg::OP_PROTCHK);
        st(32'h20, 32'h0);
        FLASH.prot_q[a0[20:16]] = 1'b1;  // As set by programming equipment
        op(a0, 8'h00, fpq_pkg::OP_PROTCHK);
        st(32'h20, 32'h20);
        op(21'h0, 8'h00, fpq_pkg::OP_RESET);
        prog(a0, d);
        rdb(a0, 8'hff);
        temp = 1'b1;
        op(21'h0, 8'h00, fpq_pkg::OP_RESET);
        pin(hv, 1'b1);
        st(32'h4, 32'h4);
        prog(a0, d);
        rdb(a0, d);
        temp = 1'b0;
        op(21'h0, 8'h00, fpq_pkg::OP_RESET);
        pin(hv, 1'b0);
        prog(a0 ^ 21'h1, d);
        rdb(a0 ^ 21'h1, 8'hff);
        FLASH.prot_q[a0[20:16]] = 1'b0;
        prog(a0 ^ 21'h1, d);
        rdb(a0 ^ 21'h1, d);
        // Writes during a supply drop must leave the byte erased
        FLASH.supply_ok = 1'b0;
        prog(a0 ^ 21'h2, d);
        FLASH.supply_ok = 1'b1;
        rdb(a0 ^ 21'h2, 8'hff);
        op(21'h0, 8'h00, fpq_pkg::OP_QUERY);
        st(32'h18, 32'h08);
        for (int i = 12; i < 80; i++) begin
            e = 8'h00;
            if (i >= 16 && i <= 76)
                e = CFI_TAB[8*(76 - i) +: 8];
            rdb({13'($urandom()), 8'(i)}, e);
        end
        rdb(21'h000043, 8'h31);
        rdb(21'h000049, 8'h04);
        rdb(21'h1fff4d, 8'h00);
        op(21'($urandom()), 8'h00, fpq_pkg::OP_RESET);
        st(32'h18, 32'h0);
        rdb(a0, d);
        op(21'h0, 8'h00, fpq_pkg::OP_IDENT);
        st(32'h18, 32'h10);
        op(21'h0, 8'h00, fpq_pkg::OP_QUERY);
        rdb(21'h10, 8'h51);
        op(21'h0, 8'h00, fpq_pkg::OP_RESET);
        st(32'h18, 32'h10);
        rdb({a0[20:16], 16'h0002}, 8'h00);
        close_out();
    end
endmodule : fpq_host_bench
